/* File: common/gpx_pkg.sv */
// shared constants and types of the i2c gpio expander
package gpx_pkg;
    localparam int GPX_PINS = 16;
    localparam logic [6:0] GPX_ADDR_BASE = 7'h20; // arbitrary base address
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_PERIOD_NS = 30;
    localparam int RST_MIN_NS = 40;
    localparam int RST_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_NS = 50;
    localparam int FILT_CYC = (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_HALF_NS = 1000000 / (2 * SCL_MAX_KHZ);
    localparam int SCL_HALF_CYC = SCL_HALF_NS / LINK_PERIOD_NS;
    // register index sits in command bits 4:1, bit 0 picks the high byte
    localparam logic [3:0] REG_IN = 4'h0;
    localparam logic [3:0] REG_OUT = 4'h1;
    localparam logic [3:0] REG_INV = 4'h2;
    localparam logic [3:0] REG_CFG = 4'h3;
    localparam logic [3:0] REG_PULL = 4'h4;
    localparam logic [3:0] REG_IEN = 4'h5;
    localparam logic [3:0] REG_TRI = 4'h6;
    localparam logic [3:0] REG_RISE = 4'h7;
    localparam logic [3:0] REG_FALL = 4'h8;
    localparam logic [3:0] REG_PEND = 4'h9;
    localparam logic [15:0] OUT_RST = 16'h0000;
    localparam logic [15:0] INV_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'hffff;
    localparam logic [15:0] PULL_RST = 16'h0000;
    localparam logic [15:0] IEN_RST = 16'h0000;
    localparam logic [15:0] TRI_RST = 16'h0000;
    localparam logic [15:0] RISE_RST = 16'h0000;
    localparam logic [15:0] FALL_RST = 16'h0000;
    typedef enum {
        LS_IDLE, LS_ADDR, LS_AACK, LS_CMD, LS_CACK, LS_WDAT, LS_WACK, LS_RD, LS_MACK
    } gpx_link_t;
endpackage

/* File: hdl/gpx_expander.sv */
// i2c slave gpio expander: link front end on i2c_clk, registers and pins on clk
`timescale 1ns/1ps
module gpx_expander
    import gpx_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = GPX_ADDR_BASE
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic i2c_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [1:0] slave_addr_select,
    input wire logic reset_pin_n,
    output logic irq_out,
    output logic irq_oe_n,
    input wire logic [GPX_PINS-1:0] port_pins_in,
    output logic [GPX_PINS-1:0] port_pins_out,
    output logic [GPX_PINS-1:0] port_pins_oe_n,
    output logic [GPX_PINS-1:0] pullup_en
);
    localparam int FW = $clog2(FILT_CYC + 1);
    localparam int RW = $clog2(RST_CYC + 1);

    function automatic logic [15:0] put_byte(logic [15:0] old, logic hi, logic [7:0] d);
        put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
    endfunction

    function automatic logic [7:0] get_byte(logic [15:0] v, logic hi);
        get_byte = hi ? v[15:8] : v[7:0];
    endfunction

    // ---------------- link domain ----------------
    logic lrst_s1_reg, lrst_reg;
    logic [1:0] scl_sy_reg, sda_sy_reg, asel_s1_reg, asel_reg;
    logic scl_f_reg, sda_f_reg, scl_d_reg, sda_d_reg;
    logic [FW-1:0] scl_cnt_reg, sda_cnt_reg;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    gpx_link_t st_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] sh_reg, ptr_reg, tx_reg, rd_buf_reg;
    logic rw_reg, sda_oe_n_reg;
    logic req_tgl_reg, req_wr_reg;
    logic [7:0] req_addr_reg, req_data_reg;
    logic [2:0] ack_sy_reg;
    logic ack_tgl_reg;
    logic [7:0] rdata_reg;

    // synchronisers; first flops feed only the second ones
    always_ff @(posedge i2c_clk) begin
        lrst_s1_reg <= sys_rst;
        lrst_reg <= lrst_s1_reg;
        scl_sy_reg <= {scl_sy_reg[0], scl_in};
        sda_sy_reg <= {sda_sy_reg[0], sda_in};
        asel_s1_reg <= slave_addr_select;
        asel_reg <= asel_s1_reg;
    end

    // glitch filter: new level only after FILT_CYC equal samples
    always_ff @(posedge i2c_clk) begin
        if (lrst_reg) begin
            scl_f_reg <= 1'b1;
            sda_f_reg <= 1'b1;
            scl_cnt_reg <= '0;
            sda_cnt_reg <= '0;
        end else begin
            if (scl_sy_reg[1] == scl_f_reg) begin
                scl_cnt_reg <= '0;
            end else if (scl_cnt_reg == FW'(FILT_CYC - 1)) begin
                scl_f_reg <= scl_sy_reg[1];
                scl_cnt_reg <= '0;
            end else begin
                scl_cnt_reg <= scl_cnt_reg + 1'b1;
            end
            if (sda_sy_reg[1] == sda_f_reg) begin
                sda_cnt_reg <= '0;
            end else if (sda_cnt_reg == FW'(FILT_CYC - 1)) begin
                sda_f_reg <= sda_sy_reg[1];
                sda_cnt_reg <= '0;
            end else begin
                sda_cnt_reg <= sda_cnt_reg + 1'b1;
            end
        end
    end

    // previous filtered levels for edge and start/stop detection
    always_ff @(posedge i2c_clk) begin
        if (lrst_reg) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_f_reg;
            sda_d_reg <= sda_f_reg;
        end
    end

    // 30 ns sampling gives about SCL_HALF_CYC samples per half period at 400 kHz
    assign scl_rise = scl_f_reg & ~scl_d_reg;
    assign scl_fall = ~scl_f_reg & scl_d_reg;
    assign start_ev = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
    assign stop_ev = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;

    // byte engine; requests cross to clk as a toggle with fields held stable
    always_ff @(posedge i2c_clk) begin
        if (lrst_reg) begin
            st_reg <= LS_IDLE;
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 8'h00;
            tx_reg <= 8'hff;
            rw_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            req_tgl_reg <= 1'b0;
            req_wr_reg <= 1'b0;
            req_addr_reg <= 8'h00;
            req_data_reg <= 8'h00;
        end else if (start_ev) begin
            st_reg <= LS_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
        end else if (stop_ev) begin
            st_reg <= LS_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else begin
            unique case (st_reg)
                LS_IDLE: begin
                end
                LS_ADDR, LS_CMD, LS_WDAT: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_f_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        if (st_reg == LS_ADDR) begin
                            // low address bits follow the select pins
                            if (sh_reg[7:1] == {ADDR_BASE[6:2], asel_reg}) begin
                                st_reg <= LS_AACK;
                                sda_oe_n_reg <= 1'b0;
                                rw_reg <= sh_reg[0];
                            end else begin
                                st_reg <= LS_IDLE;
                            end
                        end else if (st_reg == LS_CMD) begin
                            ptr_reg <= sh_reg;
                            st_reg <= LS_CACK;
                            sda_oe_n_reg <= 1'b0;
                        end else begin
                            req_tgl_reg <= ~req_tgl_reg;
                            req_wr_reg <= 1'b1;
                            req_addr_reg <= ptr_reg;
                            req_data_reg <= sh_reg;
                            st_reg <= LS_WACK;
                            sda_oe_n_reg <= 1'b0;
                        end
                    end
                end
                LS_AACK: begin
                    // fetch during the ack high phase so the byte is ready at fall
                    if (scl_rise && rw_reg) begin
                        req_tgl_reg <= ~req_tgl_reg;
                        req_wr_reg <= 1'b0;
                        req_addr_reg <= ptr_reg;
                    end
                    if (scl_fall) begin
                        if (rw_reg) begin
                            st_reg <= LS_RD;
                            sda_oe_n_reg <= rd_buf_reg[7];
                            tx_reg <= {rd_buf_reg[6:0], 1'b1};
                        end else begin
                            st_reg <= LS_CMD;
                            sda_oe_n_reg <= 1'b1;
                        end
                    end
                end
                LS_CACK, LS_WACK: begin
                    if (scl_fall) begin
                        if (st_reg == LS_WACK) begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        st_reg <= LS_WDAT;
                        sda_oe_n_reg <= 1'b1;
                    end
                end
                LS_RD: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall) begin
                        if (bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            st_reg <= LS_MACK;
                            sda_oe_n_reg <= 1'b1;
                        end else begin
                            sda_oe_n_reg <= tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b1};
                        end
                    end
                end
                LS_MACK: begin
                    if (scl_rise) begin
                        if (sda_f_reg) begin
                            st_reg <= LS_IDLE;
                        end else begin
                            ptr_reg <= ptr_reg + 8'h01;
                            req_tgl_reg <= ~req_tgl_reg;
                            req_wr_reg <= 1'b0;
                            req_addr_reg <= ptr_reg + 8'h01;
                        end
                    end
                    if (scl_fall) begin
                        st_reg <= LS_RD;
                        sda_oe_n_reg <= rd_buf_reg[7];
                        tx_reg <= {rd_buf_reg[6:0], 1'b1};
                    end
                end
            endcase
        end
    end

    // read answer returns as a toggle; rdata_reg is stable once it is seen
    always_ff @(posedge i2c_clk) begin
        if (lrst_reg) begin
            ack_sy_reg <= 3'h0;
            rd_buf_reg <= 8'hff;
        end else begin
            ack_sy_reg <= {ack_sy_reg[1:0], ack_tgl_reg};
            if (ack_sy_reg[2] != ack_sy_reg[1]) begin
                rd_buf_reg <= rdata_reg;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = sda_oe_n_reg;

    // ---------------- core domain ----------------
    logic [2:0] req_sy_reg;
    logic op_go, op_ok, op_hi, wr_go, rd_go, reg_rst;
    logic [3:0] op_idx;
    logic rpin_s1_reg, rpin_reg, hw_rst_reg, irq_oe_n_reg;
    logic [RW-1:0] rcnt_reg;
    logic [15:0] pin_s1_reg, pin_reg, pin_d_reg, in_val, rd_word;
    logic [15:0] out_reg, inv_reg, cfg_reg, pull_reg, ien_reg, tri_reg, rise_reg, fall_reg;
    logic [15:0] pend_reg, ref_reg, set_vec, ret_vec, rdclr_vec;

    assign op_go = req_sy_reg[2] ^ req_sy_reg[1];
    assign op_ok = (req_addr_reg[7:5] == 3'h0);
    assign op_idx = req_addr_reg[4:1];
    assign op_hi = req_addr_reg[0];
    assign wr_go = op_go & req_wr_reg & op_ok;
    assign rd_go = op_go & ~req_wr_reg;
    assign reg_rst = sys_rst | hw_rst_reg;

    // reset pin and gpio synchronisers
    always_ff @(posedge clk) begin
        rpin_s1_reg <= reset_pin_n;
        rpin_reg <= rpin_s1_reg;
        pin_s1_reg <= port_pins_in;
        pin_reg <= pin_s1_reg;
        pin_d_reg <= pin_reg;
    end

    // reset pin must stay low more than RST_CYC samples, so short dips are ignored
    always_ff @(posedge clk) begin
        if (sys_rst || rpin_reg) begin
            rcnt_reg <= '0;
        end else if (rcnt_reg != RW'(RST_CYC)) begin
            rcnt_reg <= rcnt_reg + 1'b1;
        end
        hw_rst_reg <= ~sys_rst & ~rpin_reg & (rcnt_reg == RW'(RST_CYC));
    end

    // configuration registers, byte written
    always_ff @(posedge clk) begin
        if (reg_rst) begin
            out_reg <= OUT_RST;
            inv_reg <= INV_RST;
            cfg_reg <= CFG_RST;
            pull_reg <= PULL_RST;
            ien_reg <= IEN_RST;
            tri_reg <= TRI_RST;
            rise_reg <= RISE_RST;
            fall_reg <= FALL_RST;
        end else if (wr_go) begin
            case (op_idx)
                REG_OUT: out_reg <= put_byte(out_reg, op_hi, req_data_reg);
                REG_INV: inv_reg <= put_byte(inv_reg, op_hi, req_data_reg);
                REG_CFG: cfg_reg <= put_byte(cfg_reg, op_hi, req_data_reg);
                REG_PULL: pull_reg <= put_byte(pull_reg, op_hi, req_data_reg);
                REG_IEN: ien_reg <= put_byte(ien_reg, op_hi, req_data_reg);
                REG_TRI: tri_reg <= put_byte(tri_reg, op_hi, req_data_reg);
                REG_RISE: rise_reg <= put_byte(rise_reg, op_hi, req_data_reg);
                REG_FALL: fall_reg <= put_byte(fall_reg, op_hi, req_data_reg);
                default: begin
                end
            endcase
        end
    end

    // interrupt sources: enabled inputs on the selected raw edges
    assign in_val = pin_reg ^ inv_reg;
    assign set_vec = ien_reg & cfg_reg & ((pin_reg & ~pin_d_reg & rise_reg)
        | (~pin_reg & pin_d_reg & fall_reg));
    assign ret_vec = pend_reg & ~(pin_reg ^ ref_reg);
    assign rdclr_vec = (rd_go && op_ok && op_idx == REG_IN)
        ? (op_hi ? 16'hff00 : 16'h00ff) : 16'h0000;

    // pending bits; a new edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reg_rst) begin
            pend_reg <= 16'h0000;
            ref_reg <= 16'h0000;
            irq_oe_n_reg <= 1'b1;
        end else begin
            pend_reg <= set_vec | (pend_reg & ~ret_vec & ~rdclr_vec);
            ref_reg <= (ref_reg & ~set_vec) | (pin_d_reg & set_vec);
            irq_oe_n_reg <= ~|pend_reg;
        end
    end

    // read mux
    always_comb begin
        case (op_idx)
            REG_IN: rd_word = in_val;
            REG_OUT: rd_word = out_reg;
            REG_INV: rd_word = inv_reg;
            REG_CFG: rd_word = cfg_reg;
            REG_PULL: rd_word = pull_reg;
            REG_IEN: rd_word = ien_reg;
            REG_TRI: rd_word = tri_reg;
            REG_RISE: rd_word = rise_reg;
            REG_FALL: rd_word = fall_reg;
            REG_PEND: rd_word = pend_reg;
            default: rd_word = 16'h0000;
        endcase
    end

    // request side of the crossing; every request is answered by a toggle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_sy_reg <= 3'h0;
            ack_tgl_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            req_sy_reg <= {req_sy_reg[1:0], req_tgl_reg};
            if (op_go) begin
                ack_tgl_reg <= ~ack_tgl_reg;
                if (!req_wr_reg) begin
                    rdata_reg <= op_ok ? get_byte(rd_word, op_hi) : 8'h00;
                end
            end
        end
    end

    // pin drive: low enable drives; input or float leaves the pin alone
    assign port_pins_out = out_reg;
    assign port_pins_oe_n = cfg_reg | tri_reg;
    assign pullup_en = pull_reg;
    assign irq_out = 1'b0;
    assign irq_oe_n = irq_oe_n_reg;

    // two clock domains here, so every check names its own clock and reset
    pull_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        pullup_en != $past(pullup_en) |->
        $past(reg_rst) || ($past(wr_go) && $past(op_idx) == REG_PULL))
        else $error("pull-up changed without a write");
    drive_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        port_pins_oe_n != $past(port_pins_oe_n) |-> $past(reg_rst) || $past(wr_go))
        else $error("pin drive changed without a write");
    invert_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        rd_go && op_ok && op_idx == REG_IN |=>
        rdata_reg == get_byte($past(pin_reg ^ inv_reg), $past(op_hi)))
        else $error("input read does not show inverted level");
    edge_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        set_vec != 16'h0000 && !reg_rst |=> (pend_reg & $past(set_vec)) == $past(set_vec))
        else $error("selected edge did not set pending");
    pend_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (~pend_reg & $past(pend_reg)) != 16'h0000 |->
        $past(reg_rst) || $past(rd_go) || $past(ret_vec) != 16'h0000)
        else $error("pending cleared without cause");
    // a register reset right after the edge may release the pin at once
    irq_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(|pend_reg) && !reg_rst |=>
        !irq_oe_n ##1 (!irq_oe_n || pend_reg == 16'h0000))
        else $error("interrupt pin not pulled low");
    hw_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        !rpin_reg && rcnt_reg == RW'(RST_CYC) |=> hw_rst_reg ##1 port_pins_oe_n == 16'hffff)
        else $error("long reset pulse did not reset pins");
    power_up_a: assert property (@(posedge clk) sys_rst |=> port_pins_oe_n == 16'hffff)
        else $error("pins not inputs after reset");
    addr_match_a: assert property (@(posedge i2c_clk) disable iff (lrst_reg)
        st_reg == LS_AACK && $past(st_reg) == LS_ADDR |->
        $past(sh_reg[2:1]) == asel_reg && !sda_oe_n_reg)
        else $error("acknowledged a foreign address");
    filter_a: assert property (@(posedge i2c_clk) disable iff (lrst_reg)
        scl_f_reg != $past(scl_f_reg) |-> $past(scl_sy_reg[1], 2) == scl_f_reg)
        else $error("scl glitch passed the filter");
    answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        op_go |=> ack_tgl_reg != $past(ack_tgl_reg))
        else $error("request not answered");

    cfg_write_c: cover property (@(posedge clk) wr_go && op_idx == REG_CFG);
    input_read_c: cover property (@(posedge clk)
        rd_go && op_idx == REG_IN && pend_reg != 16'h0000);
    irq_c: cover property (@(posedge clk) $fell(irq_oe_n));
    hw_reset_c: cover property (@(posedge clk) hw_rst_reg);
endmodule // gpx_expander

/* File: dv/gpx_i2c_master.sv */
// i2c bus master model that talks to the expander's link pins
`timescale 1ns/1ps
module gpx_i2c_master
    import gpx_pkg::*;
(
    output logic scl,
    output logic sda_oe_n,
    input wire logic sda
);
    localparam int HALF = SCL_HALF_NS;
    // bus idles with both lines released, scl stands high between frames
    initial begin
        scl = 1'h1;
        sda_oe_n = 1'h1;
    end
    // data moves well after scl falls so the slave filter never sees a false start
    task automatic clk_bit(input logic b, output logic r);
        #300 sda_oe_n = b;
        #(HALF - 300) scl = 1'h1;
        #(HALF - 10) r = sda;
        #10 scl = 1'h0;
    endtask
    // start, or repeated start when scl is already low
    task automatic start();
        if (scl === 1'h0) begin
            #300 sda_oe_n = 1'h1;
            #(HALF - 300) scl = 1'h1;
            #HALF;
        end
        sda_oe_n = 1'h0;
        #HALF scl = 1'h0;
    endtask
    task automatic stop();
        #300 sda_oe_n = 1'h0;
        #(HALF - 300) scl = 1'h1;
        #HALF sda_oe_n = 1'h1;
        #HALF;
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], q[i]);
        end
        clk_bit(ack_in, ack);
    endtask
endmodule // gpx_i2c_master

/* File: dv/tb.sv */
// self-checking bench for the i2c gpio expander
`timescale 1ns/1ps
module tb;
    import gpx_pkg::*;
    localparam logic [6:0] ADDR_OK = {GPX_ADDR_BASE[6:2], 2'h2};
    logic clk = 1'h0;
    logic i2c_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic reset_pin_n = 1'h1;
    logic [1:0] addr_sel = 2'h2;
    logic [GPX_PINS-1:0] pins_in = 16'h0000;
    logic scl, m_sda_oe_n, sda, sda_out, sda_oe_n, irq_out, irq_oe_n, irq_n;
    logic [GPX_PINS-1:0] pins_out, pins_oe_n, pullup_en;
    int errors = 0;
    int checks = 0;
    // open-drain wires with pull-ups
    assign sda = m_sda_oe_n & (sda_oe_n | sda_out);
    assign irq_n = irq_oe_n | irq_out;
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    // link clock, six clk periods; its rising edges fall on clk falling edges
    always #(LINK_PERIOD_NS / 2.0) i2c_clk = ~i2c_clk;
    gpx_expander dut (.clk(clk), .sys_rst(sys_rst), .i2c_clk(i2c_clk), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .slave_addr_select(addr_sel),
        .reset_pin_n(reset_pin_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
        .port_pins_in(pins_in), .port_pins_out(pins_out), .port_pins_oe_n(pins_oe_n),
        .pullup_en(pullup_en));
    gpx_i2c_master host (.scl(scl), .sda_oe_n(m_sda_oe_n), .sda(sda));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // settle just after a clk edge so outputs are stable when read
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_pins(input logic [15:0] v);
        @(posedge clk);
        #1 pins_in = v;
        wait_clk(10);
    endtask
    task automatic test_reset();
        check("pins_oe_n", 16'hffff, pins_oe_n);
        check("pullup_en", 16'h0000, pullup_en);
        check("irq_n", 16'h0001, {15'h0, irq_n});
        $display("test reset done");
    endtask
    // select pins moved: the usual address is foreign and left unacknowledged
    task automatic test_addr();
        logic [7:0] q;
        logic ack;
        addr_sel = 2'h1;
        host.start();
        host.xfer({ADDR_OK, 1'h0}, 1'h1, q, ack);
        host.stop();
        check("foreign addr ack", 16'h0001, {15'h0, ack});
        wait_clk(1);
        addr_sel = 2'h2;
        $display("test addr done");
    endtask
    // one burst from output low byte up to rising enable high byte
    task automatic test_config();
        logic [7:0] d[14] = '{8'h50, 8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'h3c,
                              8'h00, 8'h01, 8'h0f, 8'h00, 8'h00, 8'h01};
        logic [7:0] q;
        logic ack;
        logic nak;
        nak = 1'h0;
        host.start();
        host.xfer({ADDR_OK, 1'h0}, 1'h1, q, ack);
        check("addr ack", 16'h0000, {15'h0, ack});
        host.xfer(8'h02, 1'h1, q, ack);
        nak = ack;
        for (int i = 0; i < 14; i++) begin
            host.xfer(d[i], 1'h1, q, ack);
            nak = nak | ack;
        end
        host.stop();
        wait_clk(20);
        check("write acks", 16'h0000, {15'h0, nak});
        check("pins_out", 16'h0050, pins_out);
        check("pins_oe_n", 16'hff0f, pins_oe_n);
        check("pullup_en", 16'h3c00, pullup_en);
        $display("test config done");
    endtask
    // pin 8: rising edge only, inverted in the input view
    task automatic test_irq();
        logic [7:0] q;
        logic ack;
        set_pins(16'h8100);
        check("irq_n rise", 16'h0000, {15'h0, irq_n});
        set_pins(16'h8000);
        check("irq_n return", 16'h0001, {15'h0, irq_n});
        set_pins(16'h8100);
        check("irq_n rise again", 16'h0000, {15'h0, irq_n});
        host.start();
        host.xfer({ADDR_OK, 1'h0}, 1'h1, q, ack);
        host.xfer(8'h01, 1'h1, q, ack);
        host.start();
        host.xfer({ADDR_OK, 1'h1}, 1'h1, q, ack);
        host.xfer(8'hff, 1'h1, q, ack);
        host.stop();
        check("input high byte", 16'h0080, {8'h00, q});
        wait_clk(10);
        check("irq_n after read", 16'h0001, {15'h0, irq_n});
        set_pins(16'h8000);
        check("irq_n fall off", 16'h0001, {15'h0, irq_n});
        $display("test irq done");
    endtask
    // a 30 ns pulse is ignored, a 60 ns pulse resets the registers
    task automatic test_hw_reset();
        @(posedge clk);
        #1 reset_pin_n = 1'h0;
        wait_clk(6);
        reset_pin_n = 1'h1;
        wait_clk(20);
        check("pullup_en short", 16'h3c00, pullup_en);
        reset_pin_n = 1'h0;
        wait_clk(12);
        reset_pin_n = 1'h1;
        wait_clk(20);
        check("pins_oe_n hw", 16'hffff, pins_oe_n);
        check("pullup_en hw", 16'h0000, pullup_en);
        check("pins_out hw", 16'h0000, pins_out);
        $display("test hw reset done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 sys_rst = 1'h0;
        wait_clk(40);
        test_reset();
        test_addr();
        test_config();
        test_irq();
        test_hw_reset();
        end_sim();
    end
    // tests need about 492 us; a hang stops near 102k clk cycles
    initial begin
        #510000;
        errors++;
        $display("mismatch watchdog expected done seen timeout");
        end_sim();
    end
endmodule // tb
